// File: pwio_pkg.sv
// Shared constants, register map and types for the welder I/O sequencer.
// Assumes a single 125 MHz clock domain; times are held in ms and turned into cycles.
package pwio_pkg;

  // Clock and times
  localparam int CLK_KHZ        = 125000;
  localparam int CYC_PER_MS     = CLK_KHZ;
  localparam int CHARGE_MAX_MS  = 60000;
  localparam int END_DELAY_MS   = 40;
  localparam int SHUTTER_MIN_MS = 150;
  localparam int END_DELAY_CYC  = END_DELAY_MS * CYC_PER_MS;

  // Counter widths
  localparam int MS_W  = 17;
  localparam int DLY_W = 23;
  localparam int CHG_W = 16;
  localparam logic [CHG_W-1:0] CHARGE_MS_CNT = CHG_W'(CHARGE_MAX_MS);

  // Schedule memory
  localparam int SCHED_N  = 32;
  localparam int SCHED_AW = 5;

  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_SCHED    = 8'h08;
  localparam logic [7:0] A_WIDX     = 8'h0c;
  localparam logic [7:0] A_LIMITS   = 8'h10;
  localparam logic [7:0] A_CONFIG   = 8'h14;
  localparam logic [7:0] A_ENERGY   = 8'h18;
  localparam logic [7:0] A_IRQ_STAT = 8'h1c;
  localparam logic [7:0] A_IRQ_EN   = 8'h20;
  localparam logic [7:0] A_IRQ_CLR  = 8'h24;
  localparam logic [7:0] A_PCOUNT   = 8'h28;

  // Field positions
  localparam int CTRL_HV      = 0;
  localparam int LIM_UP_LSB   = 16;
  localparam int LIM_LO_LSB   = 0;
  localparam int CFG_WAVE_LSB = 0;
  localparam int CFG_IVL_LSB  = 8;
  localparam int CFG_RPT_LSB  = 16;
  localparam int ST_READY     = 0;
  localparam int ST_EXT       = 1;
  localparam int ST_EMIT      = 2;
  localparam int ST_END       = 3;
  localparam int ST_HIGH      = 4;
  localparam int ST_LOW       = 5;
  localparam int ST_CHARGING  = 6;
  localparam int ST_FAULT     = 7;

  // Interrupt bits
  localparam int IRQ_W     = 4;
  localparam int IRQ_READY = 0;
  localparam int IRQ_CHTO  = 1;
  localparam int IRQ_END   = 2;
  localparam int IRQ_NG    = 3;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef struct packed {
    logic [3:0]  wave;
    logic [11:0] upper;
    logic [11:0] lower;
    logic [7:0]  interval_ms;
    logic [7:0]  repeat_n;
  } pwio_sched_s;

  localparam int SCHED_W = $bits(pwio_sched_s);

  typedef struct packed {
    logic done;
    logic high;
    logic low;
  } pwio_judge_s;

  typedef enum logic [1:0] {CHG_OFF, CHG_RUN, CHG_READY, CHG_FAULT} pwio_chg_e;

endpackage : pwio_pkg

// File: pwio_plc_model.sv
// Controller model driving the mode, beam and start contacts.
// Assumes the bench raises go to weld and lowers it to stop.
`timescale 1ns/10ps
module pwio_plc_model
  import pwio_pkg::*;
#(
  parameter int MS_CYC = 10
) (
  // Clock
  input  wire logic       hclk,
  // Commands from the bench
  input  wire logic       ext_cmd,
  input  wire logic       go,
  input  wire logic [1:0] beams,
  // Connector lines
  output logic            ext_mode_pin,
  output logic            start_pin,
  output logic            beam_one_select,
  output logic            beam_two_select
);
  int wait_cnt = 0;

  initial begin
    ext_mode_pin    = 1'b0;
    start_pin       = 1'b0;
    beam_one_select = 1'b0;
    beam_two_select = 1'b0;
  end

  // A beam change opens start and restarts the shutter wait
  always @(posedge hclk) begin
    ext_mode_pin <= ext_cmd;
    if (!go || beams != {beam_two_select, beam_one_select}) begin
      start_pin       <= 1'b0;
      wait_cnt        <= 0;
      beam_one_select <= beams[0];
      beam_two_select <= beams[1];
    end else if (wait_cnt < SHUTTER_MIN_MS * MS_CYC) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      start_pin <= 1'b1;
    end
  end
endmodule : pwio_plc_model

// File: pwio_sched_mem.sv
// Schedule store: one write port, one read port with registered read data.
// Assumes both ports on the same clock; a read sees a write one cycle later.
`timescale 1ns/10ps
module pwio_sched_mem #(
  parameter int W  = 44,
  parameter int D  = 32,
  parameter int AW = 5
) (
  // Clock
  input  wire logic          hclk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [D];

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge hclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : pwio_sched_mem

// File: pwio_seq.sv
// Welder I/O sequencer: control source, start handling, charge/ready, beam gating,
// end-of-output and energy judgment, schedule store, AHB-Lite registers and interrupt.
// Assumes pins arrive asynchronously; pulse_done and energy come from on-clock logic.
`timescale 1ns/10ps
module pwio_seq
  import pwio_pkg::*;
#(
  parameter int MS_CYC  = pwio_pkg::CYC_PER_MS,
  parameter int END_CYC = pwio_pkg::END_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [31:0]                   hwdata,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Remote line connector one, closed contact reads high
  input  wire logic                          ext_mode_pin,
  input  wire logic                          start_pin,
  input  wire logic                          beam_one_select,
  input  wire logic                          beam_two_select,
  // Panel and charger pins
  input  wire logic                          panel_toggle_pin,
  input  wire logic                          charge_done_pin,
  // Laser driver, same clock
  input  wire logic                          pulse_done,
  input  wire logic [11:0]                   pulse_energy,
  output logic                               pulse_req_r,
  output pwio_pkg::pwio_sched_s              active_sched_r,
  // Outputs to the lines
  output logic                               hv_on,
  output logic                               ready_r,
  output logic                               unit_one_fire,
  output logic                               unit_two_fire,
  output pwio_pkg::pwio_judge_s              judge_r,
  // Interrupt
  output logic                               irq
);
  // Synchronisers for pins
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_sync_r;
  wire  [NPIN-1:0] pin_raw = {ext_mode_pin, start_pin, beam_one_select,
                              beam_two_select, panel_toggle_pin, charge_done_pin};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire ext_mode  = pin_sync_r[5];
  wire start_s   = pin_sync_r[4];
  wire beam_one_select_s   = pin_sync_r[3];
  wire beam_two_select_s   = pin_sync_r[2];
  wire toggle_s  = pin_sync_r[1];
  wire chg_done  = pin_sync_r[0];

  // Software-visible registers
  logic [31:0]          ctrl_r;
  logic [SCHED_AW-1:0]  sched_sel_r;
  logic [SCHED_AW-1:0]  widx_r;
  logic [23:0]          limits_r;
  logic [IRQ_W-1:0]     irq_stat_r;
  logic [IRQ_W-1:0]     irq_en_r;
  logic [11:0]          energy_r;
  logic [15:0]          pcount_r;

  // AHB address phase capture
  logic                 wr_pend_r;
  logic [7:0]           wr_addr_r;

  wire addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire rd_take  = addr_ok && !hwrite;
  wire wr_take  = addr_ok && hwrite;
  wire [7:0] a8 = haddr[7:0];

  wire wr_ctrl  = wr_pend_r && (wr_addr_r == A_CTRL);
  wire wr_sched = wr_pend_r && (wr_addr_r == A_SCHED);
  wire wr_widx  = wr_pend_r && (wr_addr_r == A_WIDX);
  wire wr_lim   = wr_pend_r && (wr_addr_r == A_LIMITS);
  wire wr_cfg   = wr_pend_r && (wr_addr_r == A_CONFIG);
  wire wr_ien   = wr_pend_r && (wr_addr_r == A_IRQ_EN);
  wire wr_iclr  = wr_pend_r && (wr_addr_r == A_IRQ_CLR);

  assign hreadyout = 1'h1;
  assign hresp     = HRESP_OKAY;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'h0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= a8;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r      <= 32'h0000_0000;
      sched_sel_r <= '0;
      widx_r      <= '0;
      limits_r    <= 24'h00_0000;
      irq_en_r    <= '0;
    end else begin
      if (wr_ctrl)  ctrl_r      <= hwdata;
      if (wr_sched) sched_sel_r <= hwdata[SCHED_AW-1:0];
      if (wr_widx)  widx_r      <= hwdata[SCHED_AW-1:0];
      if (wr_lim)   limits_r    <= {hwdata[LIM_UP_LSB+:12], hwdata[LIM_LO_LSB+:12]};
      if (wr_ien)   irq_en_r    <= hwdata[IRQ_W-1:0];
    end
  end

  // Schedule store; a write to the config word commits limits and config together
  pwio_sched_s wr_sched_word;
  logic [SCHED_W-1:0] rd_word;
  logic emit_on;

  assign wr_sched_word = '{wave:        hwdata[CFG_WAVE_LSB+:4],
                           upper:       limits_r[23:12],
                           lower:       limits_r[11:0],
                           interval_ms: hwdata[CFG_IVL_LSB+:8],
                           repeat_n:    hwdata[CFG_RPT_LSB+:8]};

  pwio_sched_mem #(
    .W  (SCHED_W),
    .D  (SCHED_N),
    .AW (SCHED_AW)
  ) u_mem (
    .hclk    (hclk),
    .wr_en   (wr_cfg),
    .wr_addr (widx_r),
    .wr_data (wr_sched_word),
    .rd_addr (sched_sel_r),
    .rd_data (rd_word)
  );

  // Active schedule is sampled only while idle, so a burst keeps its settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_sched_r <= '0;
    end else if (!emit_on) begin
      active_sched_r <= pwio_sched_s'(rd_word);
    end
  end

  // Millisecond tick
  logic [MS_W-1:0] ms_cnt_r;
  wire             ms_tick = (ms_cnt_r == MS_W'(MS_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
    end
  end

  // Charging and ready
  pwio_chg_e        chg_r;
  pwio_chg_e        chg_nxt;
  logic [CHG_W-1:0] chg_ms_r;
  wire              hv_req = ctrl_r[CTRL_HV];

  assign hv_on = hv_req;

  always_comb begin
    chg_nxt = chg_r;
    case (chg_r)
      CHG_OFF: begin
        if (hv_req) chg_nxt = CHG_RUN;
      end
      CHG_RUN: begin
        if (!hv_req) chg_nxt = CHG_OFF;
        else if (chg_done) chg_nxt = CHG_READY;
        else if (chg_ms_r == CHARGE_MS_CNT) chg_nxt = CHG_FAULT;
      end
      CHG_READY: begin
        if (!hv_req) chg_nxt = CHG_OFF;
      end
      default: begin
        if (!hv_req) chg_nxt = CHG_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_r    <= CHG_OFF;
      chg_ms_r <= '0;
      ready_r  <= 1'h0;
    end else begin
      chg_r    <= chg_nxt;
      chg_ms_r <= (chg_r != CHG_RUN) ? '0 : chg_ms_r + CHG_W'(ms_tick);
      ready_r  <= (chg_nxt == CHG_READY);
    end
  end

  // Control source and emission request
  logic toggle_d_r;
  logic panel_emit_r;
  wire  toggle_rise = toggle_s && !toggle_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toggle_d_r   <= 1'h0;
      panel_emit_r <= 1'h0;
    end else begin
      toggle_d_r <= toggle_s;
      if (ext_mode || !ready_r) panel_emit_r <= 1'h0;
      else if (toggle_rise) panel_emit_r <= !panel_emit_r;
    end
  end

  wire emit_req = ext_mode ? start_s : panel_emit_r;

  // Burst sequencing: pulses at the schedule interval until the repeat count
  logic       emit_d_r;
  logic       burst_done_r;
  logic [7:0] ivl_ms_r;
  logic [7:0] shots_r;
  assign      emit_on   = emit_req && ready_r && !burst_done_r;
  wire        emit_rise = emit_req && ready_r && !emit_d_r;
  wire [7:0]  ivl_lim   = (active_sched_r.interval_ms == 8'h00) ? 8'h01
                          : active_sched_r.interval_ms;
  wire        fire_now  = emit_on && (emit_rise || (ms_tick && ivl_ms_r + 8'h01 >= ivl_lim));
  wire        last_shot = (active_sched_r.repeat_n != 8'h00)
                          && (shots_r + 8'h01 == active_sched_r.repeat_n);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emit_d_r     <= 1'h0;
      burst_done_r <= 1'h0;
      ivl_ms_r     <= 8'h00;
      shots_r      <= 8'h00;
      pulse_req_r  <= 1'h0;
    end else begin
      emit_d_r    <= emit_req && ready_r;
      pulse_req_r <= fire_now;
      if (!(emit_req && ready_r)) begin
        burst_done_r <= 1'h0;
        shots_r      <= 8'h00;
        ivl_ms_r     <= 8'h00;
      end else if (fire_now) begin
        shots_r      <= shots_r + 8'h01;
        ivl_ms_r     <= 8'h00;
        burst_done_r <= last_shot;
      end else if (ms_tick) begin
        ivl_ms_r <= ivl_ms_r + 8'h01;
      end
    end
  end

  // Both units fire on the same pulse when both beams are selected
  assign unit_one_fire = pulse_req_r && beam_one_select_s;
  assign unit_two_fire = pulse_req_r && beam_two_select_s;

  // End-of-output delay and judgment
  logic             dly_run_r;
  logic [DLY_W-1:0] dly_cnt_r;
  wire              dly_exp = dly_run_r && (dly_cnt_r == DLY_W'(END_CYC - 1));
  wire              judge_hi = energy_r > active_sched_r.upper;
  wire              judge_lo = energy_r < active_sched_r.lower;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_run_r <= 1'h0;
      dly_cnt_r <= '0;
      energy_r  <= 12'h000;
      pcount_r  <= 16'h0000;
      judge_r   <= '0;
    end else begin
      if (pulse_done) begin
        dly_run_r <= 1'h1;
        dly_cnt_r <= '0;
        energy_r  <= pulse_energy;
        pcount_r  <= pcount_r + 16'h0001;
      end else if (dly_exp) begin
        dly_run_r <= 1'h0;
      end else if (dly_run_r) begin
        dly_cnt_r <= dly_cnt_r + 1'b1;
      end
      // A new start drops the previous result; otherwise it holds
      if (emit_rise) begin
        judge_r <= '0;
      end else if (dly_exp && !pulse_done) begin
        judge_r <= '{done: 1'h1, high: judge_hi, low: judge_lo};
      end
    end
  end

  // Interrupts: hardware set wins over a software clear in the same cycle
  logic [IRQ_W-1:0] irq_set;
  logic             ready_d_r;
  wire              fault_rise = (chg_nxt == CHG_FAULT) && (chg_r != CHG_FAULT);
  wire  [IRQ_W-1:0] irq_clr    = wr_iclr ? hwdata[IRQ_W-1:0] : '0;

  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_READY] = ready_r && !ready_d_r;
    irq_set[IRQ_CHTO]  = fault_rise;
    irq_set[IRQ_END]   = dly_exp && !pulse_done;
    irq_set[IRQ_NG]    = dly_exp && !pulse_done && (judge_hi || judge_lo);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
      ready_d_r  <= 1'h0;
    end else begin
      ready_d_r  <= ready_r;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // Read data, registered at the address phase
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  always_comb begin
    status_w              = 32'h0000_0000;
    status_w[ST_READY]    = ready_r;
    status_w[ST_EXT]      = ext_mode;
    status_w[ST_EMIT]     = emit_on;
    status_w[ST_END]      = judge_r.done;
    status_w[ST_HIGH]     = judge_r.high;
    status_w[ST_LOW]      = judge_r.low;
    status_w[ST_CHARGING] = (chg_r == CHG_RUN);
    status_w[ST_FAULT]    = (chg_r == CHG_FAULT);
  end

  always_comb begin
    if (a8 == A_CTRL)          rd_mux = ctrl_r;
    else if (a8 == A_STATUS)   rd_mux = status_w;
    else if (a8 == A_SCHED)    rd_mux = {27'h000_0000, sched_sel_r};
    else if (a8 == A_WIDX)     rd_mux = {27'h000_0000, widx_r};
    else if (a8 == A_LIMITS)   rd_mux = {4'h0, limits_r[23:12], 4'h0, limits_r[11:0]};
    else if (a8 == A_ENERGY)   rd_mux = {20'h0_0000, energy_r};
    else if (a8 == A_IRQ_STAT) rd_mux = {28'h000_0000, irq_stat_r};
    else if (a8 == A_IRQ_EN)   rd_mux = {28'h000_0000, irq_en_r};
    else if (a8 == A_PCOUNT)   rd_mux = {16'h0000, pcount_r};
    else                       rd_mux = 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_mux;
    end
  end
endmodule : pwio_seq

// File: pwio_seq_assertions.sv
// Port checker for the welder I/O sequencer.
// Assumes it is bound into pwio_seq with one clock and hresetn as reset.
`timescale 1ns/10ps
module pwio_seq_checker
  import pwio_pkg::*;
#(
  parameter int MS_CYC  = 10,
  parameter int END_CYC = 400
) (
  // Clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Bus answer
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // Connector lines
  input wire logic                  ext_mode_pin,
  input wire logic                  start_pin,
  input wire logic                  beam_one_select,
  input wire logic                  beam_two_select,
  // Laser driver
  input wire logic                  pulse_done,
  input wire logic [11:0]           pulse_energy,
  input wire logic                  pulse_req_r,
  input wire pwio_pkg::pwio_sched_s active_sched_r,
  // Outputs
  input wire logic                  hv_on,
  input wire logic                  ready_r,
  input wire logic                  unit_one_fire,
  input wire logic                  unit_two_fire,
  input wire pwio_pkg::pwio_judge_s judge_r
);
  logic [15:0] cnt_r;
  logic [11:0] e_r;
  logic [11:0] up_r;
  logic [11:0] lo_r;

  // Cycles since the last completed pulse, saturating past the judgment point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
    end else if (pulse_done) begin
      cnt_r <= 16'h0001;
    end else if (cnt_r != 16'h0000 && cnt_r < 16'(END_CYC + 2)) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge hclk) begin
    if (pulse_done) begin
      e_r  <= pulse_energy;
      up_r <= active_sched_r.upper;
      lo_r <= active_sched_r.lower;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Five samples cover the two-stage synchroniser and the request register
  sequence s_ext_open;
    ext_mode_pin && !start_pin;
  endsequence
  sequence s_beams_held;
    (beam_one_select && beam_two_select) [*4];
  endsequence

  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  a_fire_gate: assert property ((unit_one_fire || unit_two_fire) |-> pulse_req_r)
    else $error("unit fired without a pulse request");
  a_fire_both: assert property (s_beams_held ##0 pulse_req_r |-> unit_one_fire && unit_two_fire)
    else $error("both beams selected but not both units fired");
  a_ready_hv: assert property ($rose(ready_r) |-> hv_on)
    else $error("ready rose without high voltage");
  a_idle_no_req: assert property (!ready_r [*3] |-> !pulse_req_r)
    else $error("pulse requested while not ready");
  a_stop_open: assert property (s_ext_open [*5] |-> !pulse_req_r)
    else $error("pulse requested with start open");
  a_end_time: assert property (cnt_r == 16'(END_CYC + 1) |-> judge_r.done)
    else $error("end signal late");
  a_end_early: assert property ($rose(judge_r.done) |-> cnt_r == 16'(END_CYC + 1))
    else $error("end signal early");
  a_judge_val: assert property (cnt_r == 16'(END_CYC + 1) |->
    judge_r.high == (e_r > up_r) && judge_r.low == (e_r < lo_r))
    else $error("judgment outputs wrong");
  a_done_hold: assert property ($fell(judge_r.done) |-> ##[0:2] pulse_req_r)
    else $error("end signal dropped without a new start");
endmodule : pwio_seq_checker

bind pwio_seq pwio_seq_checker #(.MS_CYC(MS_CYC), .END_CYC(END_CYC)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .ext_mode_pin(ext_mode_pin), .start_pin(start_pin),
  .beam_one_select(beam_one_select), .beam_two_select(beam_two_select),
  .pulse_done(pulse_done), .pulse_energy(pulse_energy), .pulse_req_r(pulse_req_r),
  .active_sched_r(active_sched_r), .hv_on(hv_on), .ready_r(ready_r),
  .unit_one_fire(unit_one_fire), .unit_two_fire(unit_two_fire), .judge_r(judge_r));

// File: tb_top.sv
// Self-checking bench for the welder I/O sequencer.
// Assumes shortened ms and end-delay counts; the laser answers each request.
`timescale 1ns/10ps
module tb_top;
  import pwio_pkg::*;
  localparam int MSC  = 10;
  localparam int ENDC = 400;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, beams = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, ext_cmd = 1'b0, go = 1'b0;
  logic        ext_mode_pin, start_pin, beam_one_select, beam_two_select;
  logic        panel_toggle_pin = 1'b0, charge_done_pin = 1'b0, pulse_done = 1'b0;
  logic [11:0] pulse_energy = 12'h000;
  logic        pulse_req_r, hv_on, ready_r, unit_one_fire, unit_two_fire, irq;
  pwio_sched_s active_sched_r;
  pwio_judge_s judge_r;
  wire         hready = hreadyout;
  int          mismatches = 0, compares = 0;
  logic [31:0] d;

  always #4 hclk = ~hclk;
  // Laser driver answers every request one cycle later
  always @(posedge hclk) pulse_done <= pulse_req_r;

  pwio_plc_model #(.MS_CYC(MSC)) u_plc (.hclk(hclk), .ext_cmd(ext_cmd), .go(go),
    .beams(beams), .ext_mode_pin(ext_mode_pin), .start_pin(start_pin),
    .beam_one_select(beam_one_select), .beam_two_select(beam_two_select));

  pwio_seq #(.MS_CYC(MSC), .END_CYC(ENDC)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_mode_pin(ext_mode_pin), .start_pin(start_pin),
    .beam_one_select(beam_one_select), .beam_two_select(beam_two_select),
    .panel_toggle_pin(panel_toggle_pin), .charge_done_pin(charge_done_pin),
    .pulse_done(pulse_done), .pulse_energy(pulse_energy), .pulse_req_r(pulse_req_r),
    .active_sched_r(active_sched_r), .hv_on(hv_on), .ready_r(ready_r),
    .unit_one_fire(unit_one_fire), .unit_two_fire(unit_two_fire),
    .judge_r(judge_r), .irq(irq));

  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : ahb

  task pulses(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge hclk);
      if (pulse_req_r === 1'b1) n++;
    end
  endtask : pulses

  task t_regs;
    ahb(1'b0, A_STATUS, 32'h0);
    chk(d === 32'h0, "status after reset");
    ahb(1'b0, 8'h3c, 32'h0);
    chk(d === 32'h0, "unmapped read");
    ahb(1'b1, A_CTRL, 32'h1);
    ahb(1'b0, A_CTRL, 32'h0);
    chk(d[CTRL_HV] === 1'b1 && hv_on === 1'b1, "high voltage request");
  endtask : t_regs

  task t_charge;
    int n;
    repeat (30) @(posedge hclk);
    chk(ready_r === 1'b0, "ready before charge done");
    charge_done_pin <= 1'b1;
    for (n = 0; n < 10 && ready_r !== 1'b1; n++) @(posedge hclk);
    chk(ready_r === 1'b1, "ready after charge done");
    ahb(1'b0, A_IRQ_STAT, 32'h0);
    chk(d[IRQ_READY] === 1'b1, "ready event");
    ahb(1'b1, A_IRQ_EN, 32'h1);
    @(posedge hclk);
    chk(irq === 1'b1, "irq enabled");
    ahb(1'b1, A_IRQ_EN, 32'h0);
    @(posedge hclk);
    chk(irq === 1'b0, "irq masked");
    ahb(1'b1, A_IRQ_EN, 32'h1);
    ahb(1'b1, A_IRQ_CLR, 32'h1);
    @(posedge hclk);
    chk(irq === 1'b0, "irq cleared");
  endtask : t_charge

  task t_sched(input logic [4:0] idx, input logic [31:0] lim, input logic [31:0] cfg);
    pwio_sched_s exp;
    exp = '{wave: cfg[3:0], upper: lim[27:16], lower: lim[11:0],
            interval_ms: cfg[15:8], repeat_n: cfg[23:16]};
    ahb(1'b1, A_WIDX, {27'h0, idx});
    ahb(1'b1, A_LIMITS, lim);
    ahb(1'b1, A_CONFIG, cfg);
    ahb(1'b1, A_SCHED, {27'h0, idx});
    repeat (4) @(posedge hclk);
    chk(active_sched_r === exp, "schedule readback");
  endtask : t_sched

  task t_ext(input logic [11:0] en, input logic hi, input logic lo);
    int n;
    ext_cmd      <= 1'b1;
    beams        <= 2'h3;
    pulse_energy <= en;
    go           <= 1'b1;
    for (n = 0; n < 3000 && unit_one_fire !== 1'b1; n++) @(posedge hclk);
    chk(unit_one_fire === 1'b1 && unit_two_fire === 1'b1, "both units fire");
    chk(n > SHUTTER_MIN_MS * MSC, "start after shutter wait");
    for (n = 0; n < 600 && judge_r.done !== 1'b1; n++) @(posedge hclk);
    chk(n >= ENDC && n <= ENDC + 3, "end signal delay");
    chk(judge_r.high === hi && judge_r.low === lo, "judgment");
    go <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(judge_r.done === 1'b1 && judge_r.high === hi, "judgment held");
    ahb(1'b0, A_IRQ_STAT, 32'h0);
    chk(d[IRQ_END] === 1'b1 && d[IRQ_NG] === (hi | lo), "end and judgment events");
    ahb(1'b1, A_IRQ_CLR, 32'hf);
    ahb(1'b0, A_ENERGY, 32'h0);
    chk(d[11:0] === en, "measured energy");
    ahb(1'b0, A_STATUS, 32'h0);
    chk(d[ST_EXT] === 1'b1, "external control seen");
  endtask : t_ext

  task t_repeat;
    int n;
    ext_cmd <= 1'b0;
    repeat (6) @(posedge hclk);
    panel_toggle_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    panel_toggle_pin <= 1'b0;
    pulses(200, n);
    chk(n >= 4, "panel press starts emission");
    panel_toggle_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    panel_toggle_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    pulses(200, n);
    chk(n === 0, "panel press stops emission");
    ext_cmd <= 1'b1;
    go      <= 1'b1;
    for (n = 0; n < 3000 && start_pin !== 1'b1; n++) @(posedge hclk);
    pulses(200, n);
    chk(n >= 4, "emission while start closed");
    go <= 1'b0;
    repeat (6) @(posedge hclk);
    pulses(200, n);
    chk(n === 0, "no emission after start opens");
  endtask : t_repeat

  task end_of_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #(40000 * 8);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_charge();
    t_sched(5'h1f, 32'h0200_0100, 32'h0001_0205);
    t_ext(12'h300, 1'b1, 1'b0);
    t_ext(12'h080, 1'b0, 1'b1);
    t_ext(12'h180, 1'b0, 1'b0);
    t_sched(5'h01, 32'h0200_0100, 32'h0000_0205);
    t_repeat();
    end_of_test();
  end
endmodule : tb_top
